// ### design/vic_capture.sv
`timescale 1ns/1ps
module vic_capture #(
  parameter int unsigned DATA_W = 24
) (
  input  wire logic                            clock,
  input  wire logic                            rst,
  input  wire logic                            reg_wr,
  input  wire logic [vic_pkg::VIC_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]                      reg_wdata,
  input  wire logic                            line_sync_pin,
  input  wire logic                            frame_sync_pin,
  input  wire logic                            yuv_clock_qualifier,
  input  wire logic                            yuv_active_qualifier,
  input  wire logic [DATA_W-1:0]               adc0_data,
  input  wire logic [DATA_W-1:0]               adc1_data,
  input  wire logic [DATA_W-1:0]               yuv_data,
  output logic                                 pix_valid,
  output logic [DATA_W-1:0]                    pix_data,
  output logic                                 pix_from_adc1,
  output logic                                 field_id,
  output logic                                 rgb_mode,
  output vic_pkg::vic_fmt_e                    yuv_format,
  output logic                                 clamp_pulse,
  output logic                                 level_correction_pulse
);
  import vic_pkg::*;

  // ==========================================================
  // Parameter check
  if (DATA_W < 8) begin : g_chk
    $error("DATA_W below 8 is not supported");
  end

  // True when a level equals its active polarity
  function automatic logic act(input logic lvl, input logic pol);
    act = ~(lvl ^ pol);
  endfunction

  // Window test, one bit wider so offset plus length cannot wrap
  function automatic logic in_win(input logic [12:0] c, input logic [12:0] o,
                                  input logic [12:0] n);
    in_win = (c >= o) && (c < 13'(o + n));
  endfunction

  // ==========================================================
  // Configuration registers, write only
  logic [7:0]            gen_ff, fmt_ff;
  logic [VIC_LINE_W-1:0] vofs_ff, vlen_ff;
  logic [VIC_PIX_W-1:0]  hofs_ff, hlen_ff;
  logic [VIC_DLY_W-1:0]  cls_ff, cle_ff, lfs_ff, lfe_ff;

  // Low byte at the odd-numbered subaddress, upper bits at the next
  always_ff @(posedge clock) begin
    if (rst) begin
      gen_ff  <= VIC_CFG_RST;
      fmt_ff  <= VIC_CFG_RST;
      vofs_ff <= VIC_WIN_RST[VIC_LINE_W-1:0];
      vlen_ff <= VIC_WIN_RST[VIC_LINE_W-1:0];
      hofs_ff <= VIC_WIN_RST;
      hlen_ff <= VIC_WIN_RST;
      cls_ff  <= VIC_DLY_RST;
      cle_ff  <= VIC_DLY_RST;
      lfs_ff  <= VIC_DLY_RST;
      lfe_ff  <= VIC_DLY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        VIC_A_GEN:    gen_ff <= reg_wdata;
        VIC_A_FMT:    fmt_ff <= reg_wdata;
        VIC_A_VOFS_L: vofs_ff[7:0] <= reg_wdata;
        VIC_A_VOFS_H: vofs_ff[10:8] <= reg_wdata[2:0];
        VIC_A_HOFS_L: hofs_ff[7:0] <= reg_wdata;
        VIC_A_HOFS_H: hofs_ff[11:8] <= reg_wdata[3:0];
        VIC_A_VLEN_L: vlen_ff[7:0] <= reg_wdata;
        VIC_A_VLEN_H: vlen_ff[10:8] <= reg_wdata[2:0];
        VIC_A_HLEN_L: hlen_ff[7:0] <= reg_wdata;
        VIC_A_HLEN_H: hlen_ff[11:8] <= reg_wdata[3:0];
        VIC_A_CLS:    cls_ff <= reg_wdata;
        VIC_A_CLE:    cle_ff <= reg_wdata;
        VIC_A_LFS:    lfs_ff <= reg_wdata;
        VIC_A_LFE:    lfe_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  logic     is_rgb, samp_en;
  vic_fld_e fld_mode;
  assign is_rgb   = gen_ff[VIC_G_RGB];
  assign samp_en  = gen_ff[VIC_G_EN];
  assign fld_mode = vic_fld_e'(fmt_ff[VIC_F_FLD +: 2]);
  assign rgb_mode = is_rgb;
  assign yuv_format = vic_fmt_e'(fmt_ff[VIC_F_FMT +: 2]);

  // ==========================================================
  // Pin synchronisers: three stages, level accepted once 2 and 3 agree
  // Bit 0 line sync, 1 frame sync, 2 clock qualifier, 3 active qualifier
  logic [3:0] s1_ff, s2_ff, s3_ff, lvl_ff, lvl_q_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff    <= 4'h0;
      s2_ff    <= 4'h0;
      s3_ff    <= 4'h0;
      lvl_ff   <= 4'h0;
      lvl_q_ff <= 4'h0;
    end else begin
      s1_ff    <= {yuv_active_qualifier, yuv_clock_qualifier, frame_sync_pin, line_sync_pin};
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      lvl_ff   <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
      lvl_q_ff <= lvl_ff;
    end
  end

  // Active-high sync is asserted by a rising pin, so its end is the falling edge
  logic hs_act, hs_was, vs_act, vs_was, hs_lead, hs_trail, vs_lead, vs_trail;
  assign hs_act   = act(lvl_ff[0], gen_ff[VIC_G_HPOL]);
  assign hs_was   = act(lvl_q_ff[0], gen_ff[VIC_G_HPOL]);
  assign vs_act   = act(lvl_ff[1], gen_ff[VIC_G_VPOL]);
  assign vs_was   = act(lvl_q_ff[1], gen_ff[VIC_G_VPOL]);
  assign hs_lead  = hs_act & ~hs_was;
  assign hs_trail = ~hs_act & hs_was;
  assign vs_lead  = vs_act & ~vs_was;
  assign vs_trail = ~vs_act & vs_was;

  logic q_ok;
  assign q_ok = act(lvl_ff[2], fmt_ff[VIC_F_QPOL]);

  // ==========================================================
  // Field identity latched at frame sync lead
  logic field_ff, alt_ff, fld_ok, fld_raw;
  assign fld_raw = ~hs_act ^ fmt_ff[VIC_F_INV];
  always_ff @(posedge clock) begin
    if (rst) begin
      field_ff <= 1'b0;
      alt_ff   <= 1'b0;
    end else if (vs_lead) begin
      field_ff <= fld_raw;
      alt_ff   <= ~alt_ff;
    end
  end

  // Decoded every cycle so a mode write mid-field never lets a wrong field through
  always_comb begin
    case (fld_mode)
      VIC_FLD_ALL:  fld_ok = 1'b1;
      VIC_FLD_ALT:  fld_ok = alt_ff;
      VIC_FLD_ODD:  fld_ok = field_ff;
      VIC_FLD_EVEN: fld_ok = ~field_ff;
      default:      fld_ok = 1'b1;
    endcase
  end

  // ==========================================================
  // Line and pixel counters; both saturate so no window recurs in a line
  logic [VIC_LINE_W-1:0] line_ff;
  logic [VIC_PIX_W-1:0]  pix_ff;
  logic                  pix_tick;
  // YUV counts only clocks marked by the clock qualifier
  assign pix_tick = is_rgb | q_ok;
  always_ff @(posedge clock) begin
    if (rst) begin
      line_ff <= '0;
    end else if (vs_trail) begin
      line_ff <= '0;
    end else if (hs_trail && line_ff != '1) begin
      line_ff <= line_ff + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pix_ff <= '0;
    end else if (hs_trail) begin
      pix_ff <= '0;
    end else if (pix_tick && pix_ff != '1) begin
      pix_ff <= pix_ff + 1'b1;
    end
  end

  // ==========================================================
  // Capture decision and converter alternation
  logic in_v, in_h, cap, phase_ff, use_adc1;
  assign in_v = in_win({2'b00, line_ff}, {2'b00, vofs_ff}, {2'b00, vlen_ff});
  assign in_h = in_win({1'b0, pix_ff}, {1'b0, hofs_ff}, {1'b0, hlen_ff});
  assign cap  = samp_en & in_v & in_h & ~hs_trail & ~vs_trail &
                (is_rgb | (q_ok & fld_ok & act(lvl_ff[3], fmt_ff[VIC_F_APOL])));
  assign use_adc1 = phase_ff ^ gen_ff[VIC_G_ORDER];

  // Phase restarts each line so the programmed converter always goes first
  always_ff @(posedge clock) begin
    if (rst || hs_trail) begin
      phase_ff <= 1'b0;
    end else if (cap && is_rgb) begin
      phase_ff <= ~phase_ff;
    end
  end

  logic              vld_ff, adc1_ff, fid_ff;
  logic [DATA_W-1:0] data_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      vld_ff  <= 1'b0;
      data_ff <= '0;
      adc1_ff <= 1'b0;
      fid_ff  <= 1'b0;
    end else begin
      vld_ff <= cap;
      if (cap) begin
        data_ff <= !is_rgb ? yuv_data : (use_adc1 ? adc1_data : adc0_data);
        adc1_ff <= is_rgb & use_adc1;
        // Non-interlaced RGB has no field, so the identity reads zero
        fid_ff  <= (is_rgb && !gen_ff[VIC_G_ILACE]) ? 1'b0 : field_ff;
      end
    end
  end
  assign pix_valid     = vld_ff;
  assign pix_data      = data_ff;
  assign pix_from_adc1 = adc1_ff;
  assign field_id      = fid_ff;

  // ==========================================================
  // Delay counters from the leading and trailing line sync edges
  logic [VIC_DLY_W-1:0] ld_cnt_ff, tr_cnt_ff;
  logic                 ld_run_ff, tr_run_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      ld_cnt_ff <= '0;
      ld_run_ff <= 1'b0;
    end else if (hs_lead) begin
      ld_cnt_ff <= '0;
      ld_run_ff <= 1'b1;
    end else if (ld_run_ff) begin
      ld_cnt_ff <= ld_cnt_ff + 1'b1;
      ld_run_ff <= (ld_cnt_ff != '1); // Stop after 255 so compares fire once
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tr_cnt_ff <= '0;
      tr_run_ff <= 1'b0;
    end else if (hs_trail) begin
      tr_cnt_ff <= '0;
      tr_run_ff <= 1'b1;
    end else if (tr_run_ff) begin
      tr_cnt_ff <= tr_cnt_ff + 1'b1;
      tr_run_ff <= (tr_cnt_ff != '1);
    end
  end

  // ==========================================================
  // Pulse state; release wins if both compares hit in one cycle
  logic clamp_on_ff, lvl_on_ff, clamp_pin_ff, lvl_pin_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      clamp_on_ff <= 1'b0;
    end else if (ld_run_ff && ld_cnt_ff == cle_ff) begin
      clamp_on_ff <= 1'b0;
    end else if (ld_run_ff && ld_cnt_ff == cls_ff) begin
      clamp_on_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lvl_on_ff <= 1'b0;
    end else if (tr_run_ff && tr_cnt_ff == lfe_ff) begin
      lvl_on_ff <= 1'b0;
    end else if (ld_run_ff && ld_cnt_ff == lfs_ff) begin
      lvl_on_ff <= 1'b1;
    end
  end

  // Pins register the polarity so the analog side sees no glitch on a write
  always_ff @(posedge clock) begin
    if (rst) begin
      clamp_pin_ff <= 1'b1;
      lvl_pin_ff   <= 1'b1;
    end else begin
      clamp_pin_ff <= ~(clamp_on_ff ^ gen_ff[VIC_G_CPOL]);
      lvl_pin_ff   <= ~(lvl_on_ff ^ gen_ff[VIC_G_LPOL]);
    end
  end
  assign clamp_pulse            = clamp_pin_ff;
  assign level_correction_pulse = lvl_pin_ff;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Line start followed by five idle counts, as with a start pixel of five
  sequence s_line_gap;
    hs_trail ##1 (!cap)[*5];
  endsequence
  sequence s_clamp_hit;
    ld_run_ff && ld_cnt_ff == cls_ff && ld_cnt_ff != cle_ff;
  endsequence

  AST_HS_EDGE: assert property (hs_trail |-> $past(s2_ff[0]) != gen_ff[VIC_G_HPOL] &&
    $past(s3_ff[0]) != gen_ff[VIC_G_HPOL])
    else $error("line start on wrong sync edge");
  AST_VS_LINE0: assert property (vs_trail && !vs_lead ##1 !hs_trail |-> line_ff == '0)
    else $error("line count not cleared at frame start");
  AST_CLAMP_ON: assert property (s_clamp_hit ##1 1'b1 |=>
    clamp_pin_ff == $past(gen_ff[VIC_G_CPOL]))
    else $error("clamp pulse not asserted at start count");
  AST_CLAMP_OFF: assert property (ld_run_ff && ld_cnt_ff == cle_ff |=> !clamp_on_ff)
    else $error("clamp pulse not released at end count");
  AST_LF_OFF: assert property (tr_run_ff && tr_cnt_ff == lfe_ff |=> !lvl_on_ff ##1
    lvl_pin_ff == !$past(gen_ff[VIC_G_LPOL]))
    else $error("level pulse not released");
  AST_NO_SAMPLE: assert property (!samp_en |=> !pix_valid)
    else $error("data captured while sampling off");
  AST_FIRST_ADC: assert property (s_line_gap ##1 (cap && is_rgb) |=>
    pix_from_adc1 == $past(gen_ff[VIC_G_ORDER]))
    else $error("wrong converter sampled first");
  AST_FLD_ODD: assert property (pix_valid && !$past(is_rgb) && $past(fld_mode) == VIC_FLD_ODD
    |-> $past(field_ff))
    else $error("even field captured in odd-only mode");
  AST_WIN: assert property (pix_valid |-> $past(line_ff) >= $past(vofs_ff) &&
    $past(pix_ff) >= $past(hofs_ff))
    else $error("capture outside window");
  AST_YUV_QUAL: assert property (pix_valid && !$past(is_rgb) |->
    $past(lvl_ff[2]) == $past(fmt_ff[VIC_F_QPOL]) &&
    $past(lvl_ff[3]) == $past(fmt_ff[VIC_F_APOL]))
    else $error("YUV capture without qualifiers");
  AST_FLD_INV: assert property (vs_lead |=> field_ff ==
    (($past(lvl_ff[0]) != $past(gen_ff[VIC_G_HPOL])) != $past(fmt_ff[VIC_F_INV])))
    else $error("field identity wrong");

endmodule // vic_capture

// ### design/vic_pkg.sv
package vic_pkg;

  // ==========================================================
  // Register subaddresses
  localparam int unsigned       VIC_ADDR_W = 8;
  localparam logic [7:0] VIC_A_GEN    = 8'h21;
  localparam logic [7:0] VIC_A_FMT    = 8'h22;
  localparam logic [7:0] VIC_A_VOFS_L = 8'h23;
  localparam logic [7:0] VIC_A_VOFS_H = 8'h24;
  localparam logic [7:0] VIC_A_HOFS_L = 8'h25;
  localparam logic [7:0] VIC_A_HOFS_H = 8'h26;
  localparam logic [7:0] VIC_A_VLEN_L = 8'h27;
  localparam logic [7:0] VIC_A_VLEN_H = 8'h28;
  localparam logic [7:0] VIC_A_HLEN_L = 8'h29;
  localparam logic [7:0] VIC_A_HLEN_H = 8'h2A;
  localparam logic [7:0] VIC_A_CLS    = 8'h2B;
  localparam logic [7:0] VIC_A_CLE    = 8'h2C;
  localparam logic [7:0] VIC_A_LFS    = 8'h2D;
  localparam logic [7:0] VIC_A_LFE    = 8'h2E;

  // ==========================================================
  // Field positions
  localparam int unsigned VIC_G_HPOL  = 0;
  localparam int unsigned VIC_G_VPOL  = 1;
  localparam int unsigned VIC_G_CPOL  = 2;
  localparam int unsigned VIC_G_LPOL  = 3;
  localparam int unsigned VIC_G_ORDER = 4;
  localparam int unsigned VIC_G_RGB   = 5;
  localparam int unsigned VIC_G_EN    = 6;
  localparam int unsigned VIC_G_ILACE = 7;
  localparam int unsigned VIC_F_QPOL  = 0;
  localparam int unsigned VIC_F_APOL  = 1;
  localparam int unsigned VIC_F_FMT   = 2;
  localparam int unsigned VIC_F_FLD   = 4;
  localparam int unsigned VIC_F_INV   = 6;

  // ==========================================================
  // Widths and values after reset
  localparam int unsigned VIC_LINE_W = 11;
  localparam int unsigned VIC_PIX_W  = 12;
  localparam int unsigned VIC_DLY_W  = 8;
  localparam logic [7:0]  VIC_CFG_RST = 8'h00;
  localparam logic [11:0] VIC_WIN_RST = 12'h000;
  localparam logic [7:0]  VIC_DLY_RST = 8'h00;

  typedef enum logic [1:0] {VIC_FLD_ALL, VIC_FLD_ALT, VIC_FLD_ODD, VIC_FLD_EVEN} vic_fld_e;
  typedef enum logic [1:0] {VIC_YUV_656, VIC_YUV_411, VIC_YUV_422, VIC_YUV_444} vic_fmt_e;

endpackage

// ### bench/vic_src_model.sv
`timescale 1ns/1ps
// Video source: 64 clocks a line, 8 lines a frame, two frames a period
module vic_src_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hs_hi,
  input  wire logic        vs_hi,
  input  wire logic        cq_hi,
  input  wire logic        aq_hi,
  output logic             line_sync_pin,
  output logic             frame_sync_pin,
  output logic             yuv_clock_qualifier,
  output logic             yuv_active_qualifier,
  output logic [23:0]      adc0_data,
  output logic [23:0]      adc1_data,
  output logic [23:0]      yuv_data
);
  logic [10:0] cyc_ff;
  logic [5:0]  pos;
  logic [5:0]  fst;
  logic        f_act;

  // ==========================================================
  // Position counter
  always_ff @(posedge clock) begin
    if (rst) begin
      cyc_ff <= 11'h000;
    end else begin
      cyc_ff <= cyc_ff + 11'h001;
    end
  end

  // ==========================================================
  // One frame starts inside line sync, the next mid-line, so fields alternate
  assign pos = cyc_ff[5:0];
  assign fst = cyc_ff[9] ? 6'h02 : 6'h20;
  assign f_act = (cyc_ff[8:6] == 3'h0) && (pos >= fst) && (pos < fst + 6'h10);
  assign line_sync_pin = (pos < 6'h04) ~^ hs_hi;
  assign frame_sync_pin = f_act ~^ vs_hi;
  // Clock qualifier active three clocks of four, data qualifier always
  assign yuv_clock_qualifier = (cyc_ff[1:0] != 2'h0) ~^ cq_hi;
  assign yuv_active_qualifier = aq_hi;
  // Ramps tagged per source so a wrong pick shows up
  assign adc0_data = {8'hA0, 5'h00, cyc_ff};
  assign adc1_data = {8'hB1, 5'h00, cyc_ff};
  assign yuv_data = {8'hC2, 5'h00, cyc_ff};
endmodule // vic_src_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import vic_pkg::*;
  logic        clock, rst, reg_wr, hs_hi, vs_hi, cq_hi, aq_hi;
  logic [7:0]  reg_addr, reg_wdata;
  logic        ls, fs, cq, aq, pix_valid, pix_from_adc1, field_id, rgb_mode;
  logic        clamp_pulse, level_correction_pulse, pv_q, ord, yuv_m, mon_on, cpol, lpol;
  logic [23:0] a0, a1, yd, pix_data, p0, p1, py;
  vic_fmt_e    yuv_format;
  int          miscompares, cmp_count, pix_n, odd_n, cl_n, lv_n, k;
  int          ex_pix[5] = '{180, 90, 90, 90, 90};
  int          ex_odd[5] = '{90, -1, 90, 0, 90};

  vic_capture #(.DATA_W(24)) uut (.clock(clock), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .line_sync_pin(ls), .frame_sync_pin(fs),
    .yuv_clock_qualifier(cq), .yuv_active_qualifier(aq), .adc0_data(a0), .adc1_data(a1),
    .yuv_data(yd), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_from_adc1(pix_from_adc1), .field_id(field_id), .rgb_mode(rgb_mode),
    .yuv_format(yuv_format), .clamp_pulse(clamp_pulse),
    .level_correction_pulse(level_correction_pulse));

  vic_src_model src (.clock(clock), .rst(rst), .hs_hi(hs_hi), .vs_hi(vs_hi), .cq_hi(cq_hi),
    .aq_hi(aq_hi), .line_sync_pin(ls), .frame_sync_pin(fs), .yuv_clock_qualifier(cq),
    .yuv_active_qualifier(aq), .adc0_data(a0), .adc1_data(a1), .yuv_data(yd));

  // ==========================================================
  // Clock and compare helpers
  always #5 clock = ~clock;

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    chk_val(32'(got), 32'(exp));
  endtask

  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Register writes: strobe held across back-to-back bytes, dropped once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask

  task automatic wr_end;
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  // Counting window on falling edges so the monitor never races the reset of counts
  task automatic measure(input int n);
    repeat (1100) @(posedge clock);
    @(negedge clock);
    pix_n = 0;
    odd_n = 0;
    cl_n = 0;
    lv_n = 0;
    mon_on = 1'b1;
    repeat (n) @(negedge clock);
    mon_on = 1'b0;
    @(posedge clock);
  endtask

  // ==========================================================
  // Pixel monitor: source pick and data checked against the delayed ramps
  always @(posedge clock) begin
    p0 <= a0;
    p1 <= a1;
    py <= yd;
    pv_q <= pix_valid;
    if (pix_valid === 1'b1) begin
      k = (pv_q === 1'b1) ? k + 1 : 0;
    end
    if (mon_on) begin
      if (clamp_pulse === cpol) cl_n++;
      if (level_correction_pulse === lpol) lv_n++;
      if (pix_valid === 1'b1) begin
        pix_n++;
        if (field_id === 1'b1) odd_n++;
        if (yuv_m) begin
          chk_val(pix_data, py);
        end else begin
          chk_val(pix_from_adc1, k[0] ^ ord);
          chk_val(pix_data, (k[0] ^ ord) ? p1 : p0);
        end
      end
    end
  end

  // Watchdog sized well above the planned run of about 25000 clocks
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    give_verdict;
  end

  // ==========================================================
  // Main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    hs_hi = 1'b0;
    vs_hi = 1'b0;
    cq_hi = 1'b0;
    aq_hi = 1'b0;
    ord = 1'b0;
    yuv_m = 1'b0;
    mon_on = 1'b0;
    cpol = 1'b0;
    lpol = 1'b0;
    k = 0;
    miscompares = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk_val(clamp_pulse, 1'b1);
    chk_val(level_correction_pulse, 1'b1);
    chk_val(rgb_mode, 1'b0);
    @(posedge clock);
    for (int f = 0; f < 4; f++) begin
      wr(VIC_A_FMT, {4'h0, 2'(f), 2'b00});
      wr_end;
      chk_val(yuv_format, 32'(f));
    end
    // Unmapped subaddress must leave the mode bits alone
    wr(8'h30, 8'hFF);
    wr_end;
    chk_val(rgb_mode, 1'b0);
    wr(VIC_A_VOFS_L, 8'h02);
    wr(VIC_A_VOFS_H, 8'h00);
    wr(VIC_A_HOFS_L, 8'h05);
    wr(VIC_A_HOFS_H, 8'h00);
    wr(VIC_A_VLEN_L, 8'h03);
    wr(VIC_A_VLEN_H, 8'h00);
    wr(VIC_A_HLEN_L, 8'h06);
    wr(VIC_A_HLEN_H, 8'h00);
    wr(VIC_A_CLS, 8'h02);
    wr(VIC_A_CLE, 8'h05);
    wr(VIC_A_LFS, 8'h01);
    wr(VIC_A_LFE, 8'h03);
    // RGB with every polarity and the converter order flipped together
    for (int p = 0; p < 2; p++) begin
      hs_hi <= p[0];
      vs_hi <= p[0];
      ord = p[0];
      cpol = p[0];
      lpol = p[0];
      wr(VIC_A_GEN, {3'b011, {5{p[0]}}});
      wr_end;
      measure(64);
      chk_cnt(cl_n, 3);
      chk_cnt(lv_n, 6);
      measure(1024);
      chk_cnt(pix_n, 36);
      chk_cnt(odd_n, 0);
    end
    wr(VIC_A_GEN, 8'hFF);
    wr_end;
    measure(1024);
    chk_cnt(pix_n, 36);
    chk_cnt(odd_n, 18);
    wr(VIC_A_GEN, 8'hBF);
    wr_end;
    chk_val(rgb_mode, 1'b1);
    measure(1024);
    chk_cnt(pix_n, 0);
    // YUV field modes; the clock qualifier gates the pixel count
    yuv_m = 1'b1;
    cq_hi <= 1'b1;
    aq_hi <= 1'b1;
    wr(VIC_A_HLEN_L, 8'h1E);
    wr(VIC_A_GEN, 8'h5F);
    for (int i = 0; i < 5; i++) begin
      wr(VIC_A_FMT, {1'b0, i == 4, (i == 4) ? 2'b10 : 2'(i), 4'h3});
      wr_end;
      measure(1024);
      chk_cnt(pix_n, ex_pix[i]);
      if (ex_odd[i] >= 0) chk_cnt(odd_n, ex_odd[i]);
    end
    cq_hi <= 1'b0;
    aq_hi <= 1'b0;
    wr(VIC_A_FMT, 8'h00);
    wr_end;
    measure(1024);
    chk_cnt(pix_n, 180);
    wr(VIC_A_FMT, 8'h02);
    wr_end;
    measure(1024);
    chk_cnt(pix_n, 0);
    give_verdict;
  end
endmodule // tb_top
